// ==== include/adc_port_pkg.sv ====
// shared constants and carriers for the converter serial register port
// assumes a single 250 MHz system clock; every user writes adc_port_pkg::name
package adc_port_pkg;

	// ==========================================================
	// serial word layout
	localparam int WORD_BITS = 16;
	localparam int DATA_BITS = 14;
	localparam logic [4:0] BIT_CNT_LAST = 5'h0F;

	// write address codes, top two bits of a word
	localparam logic [1:0] WADDR_NONE = 2'h0;
	localparam logic [1:0] WADDR_TEST = 2'h1;
	localparam logic [1:0] WADDR_CAL = 2'h2;
	localparam logic [1:0] WADDR_CTRL = 2'h3;

	// read source codes held in the control register
	localparam logic [1:0] RSEL_RESULT = 2'h0;
	localparam logic [1:0] RSEL_TEST = 2'h1;
	localparam logic [1:0] RSEL_CAL = 2'h2;
	localparam logic [1:0] RSEL_STATUS = 2'h3;

	// ==========================================================
	// control register fields and reset
	localparam logic [13:0] CTRL_RESET = 14'h0000;
	localparam logic [13:0] TEST_RESET = 14'h0000;
	localparam logic [13:0] CAL_RESET = 14'h0000;
	localparam int CTRL_RDSEL_LO = 6;
	localparam int CTRL_RDSEL_HI = 7;
	localparam int CTRL_MODE1_BIT = 5;
	localparam int CTRL_CONVST_BIT = 4;
	localparam int CTRL_STCAL_BIT = 0;

	// status register fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_CAL_BIT = 1;
	localparam int STAT_OVR_BIT = 2;
	localparam int STAT_MODE1_BIT = 3;
	localparam int STAT_PTR_LO = 4;
	localparam int STAT_PTR_HI = 7;

	// ==========================================================
	// calibration bank and master clock timing
	localparam int CAL_REG_COUNT = 10;
	localparam int CAL_PTR_W = 4;
	localparam int CONV_MCLKS = 18;
	localparam int CAL_MCLKS = 64;
	localparam int MCLK_CNT_W = 8;

	// received word as it travels through the buffer
	typedef struct packed {
		logic [1:0] addr;
		logic [13:0] data;
	} rx_word_type;

	// converter activity
	typedef enum logic [1:0] {
		OP_IDLE,
		OP_CONVERT,
		OP_CALIBRATE
	} op_state_type;

endpackage

// ==== design/pin_sync.sv ====
// two flip-flop synchroniser for a bus of unrelated inputs
// assumes the bits are independent levels; no word coherency is given
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	input wire logic ce,
	// raw and synchronised levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	// ==========================================================
	// width check
	if (WIDTH < 1) begin : g_bad_width
		$error("pin_sync width must be at least one");
	end

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] stable_ff;

	// first stage feeds only the second stage
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			meta_ff <= '0;
			stable_ff <= '0;
		end else if (ce) begin
			meta_ff <= async_in;
			stable_ff <= meta_ff;
		end
	end

	assign sync_out = stable_ff;

endmodule

`default_nettype wire

// ==== design/two_entry_buffer.sv ====
// small first-in first-out buffer with valid/ready on both sides
// assumes both sides on the same clock; default depth is two words
`timescale 1ns/1ps
`default_nettype none

module two_entry_buffer #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 2
) (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	input wire logic ce,
	// filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	// ==========================================================
	// parameter checks
	if (DEPTH < 2 || WIDTH < 1) begin : g_bad_shape
		$error("two_entry_buffer needs depth of two or more");
	end

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [PW-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
	logic [CW-1:0] count_ff, nxt_count;
	logic push, pop;

	// honest full and empty
	assign in_ready = (count_ff != CW'(DEPTH));
	assign out_valid = (count_ff != '0);
	assign out_data = mem_ff[rd_ptr_ff];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// pointer and occupancy next values
	always_comb begin
		nxt_wr_ptr = wr_ptr_ff;
		nxt_rd_ptr = rd_ptr_ff;
		nxt_count = count_ff;
		if (push) begin
			nxt_wr_ptr = (wr_ptr_ff == PW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
		end
		if (pop) begin
			nxt_rd_ptr = (rd_ptr_ff == PW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
		end
		if (push && !pop) begin
			nxt_count = count_ff + 1'b1;
		end else if (pop && !push) begin
			nxt_count = count_ff - 1'b1;
		end
	end

	// registers
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else if (ce) begin
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
			count_ff <= nxt_count;
		end
	end

	// storage, written only on an accepted push
	always_ff @(posedge clock) begin
		if (ce && push) begin
			mem_ff[wr_ptr_ff] <= in_data;
		end
	end

endmodule

`default_nettype wire

// ==== design/adc_serial_register_port.sv ====
// serial host port and register set of a multi-channel sampling converter
// assumes the host makes the serial clock and frame; all pins are sampled on clock
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - read words leave on the data output, sixteen bits, most significant first
// - data input pin turns to output for reads when interface mode one is set
// - frame sync is active low; transfers happen only while it is low
// - conversion and calibration lengths are counted in master clock edges
// - reset gives defaults; nothing needs writing before a result read
// - software conversion start and calibration need extra control writes
// - control, result, status, test and ten calibration registers exist
// - control write only, result and status read only, test and calibration both
// - top two bits pick none, test, calibration or control; fourteen bits data
// - a write lands only after all sixteen bits arrived
// - two control bits pick the read source; reset selects the result
module adc_serial_register_port #(
	parameter int CAL_REGS = adc_port_pkg::CAL_REG_COUNT,
	parameter int CONV_MCLKS = adc_port_pkg::CONV_MCLKS,
	parameter int CAL_MCLKS = adc_port_pkg::CAL_MCLKS
) (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	input wire logic ce,
	// serial link pins
	input wire logic sclk,
	input wire logic sync_n,
	input wire logic din_i,
	output logic din_o,
	output logic din_oe,
	output logic dout,
	// converter core side
	input wire logic master_clock_in,
	input wire logic [13:0] sample_data,
	output logic busy,
	output logic word_ready,
	output logic [13:0] ctrl_out
);

	localparam int MW = adc_port_pkg::MCLK_CNT_W;
	// ==========================================================
	// parameter checks
	if (CAL_REGS < 1 || CAL_REGS > 15 || CONV_MCLKS < 1 || CAL_MCLKS < 1 ||
		CONV_MCLKS > 2 ** MW || CAL_MCLKS > 2 ** MW) begin : g_bad_param
		$error("adc_serial_register_port parameters out of range");
	end

	// ==========================================================
	// pin synchronisers; clock and frame enter inverted so cleared flops match their idle high level
	logic [3:0] pins_s;
	logic sclk_low_s, sclk_s, frame_s, din_s, mclk_s;

	pin_sync #(.WIDTH(4)) u_pin_sync (
		.clock(clock),
		.nrst(nrst),
		.ce(ce),
		.async_in({~sclk, ~sync_n, din_i, master_clock_in}),
		.sync_out(pins_s)
	);
	assign {sclk_low_s, frame_s, din_s, mclk_s} = pins_s;
	assign sclk_s = !sclk_low_s;

	// ==========================================================
	// serial shifter state
	logic frame_ff, nxt_frame, sclk_ff, nxt_sclk, mclk_ff, nxt_mclk;
	logic mode1_frame_ff, nxt_mode1_frame, done_ff, nxt_done;
	logic [4:0] bit_cnt_ff, nxt_bit_cnt;
	logic [15:0] rx_sh_ff, nxt_rx_sh, tx_sh_ff, nxt_tx_sh;
	logic [13:0] ctrl_ff, nxt_ctrl;
	logic frame, frame_start, sclk_rise, sclk_fall, mclk_rise, push;
	logic [15:0] rd_word;
	adc_port_pkg::rx_word_type in_word, head_word;
	logic buf_in_ready, buf_valid, buf_ready, pop;

	assign frame = frame_s;
	assign frame_start = frame && !frame_ff;
	assign sclk_rise = sclk_s && !sclk_ff;
	assign sclk_fall = !sclk_s && sclk_ff;
	assign mclk_rise = mclk_s && !mclk_ff;
	assign in_word = adc_port_pkg::rx_word_type'({rx_sh_ff[14:0], din_s});

	// shift in on falling, shift out on rising serial clock
	always_comb begin
		nxt_frame = frame;
		nxt_sclk = sclk_s;
		nxt_mclk = mclk_s;
		nxt_mode1_frame = mode1_frame_ff;
		nxt_done = done_ff;
		nxt_bit_cnt = bit_cnt_ff;
		nxt_rx_sh = rx_sh_ff;
		nxt_tx_sh = tx_sh_ff;
		push = 1'b0;
		if (frame_start) begin
			nxt_tx_sh = rd_word;
			nxt_bit_cnt = '0;
			nxt_done = 1'b0;
			nxt_mode1_frame = ctrl_ff[adc_port_pkg::CTRL_MODE1_BIT];
		end else if (frame) begin
			if (sclk_rise) begin
				nxt_tx_sh = {tx_sh_ff[14:0], 1'b0};
			end
			if (sclk_fall && !done_ff && !mode1_frame_ff) begin
				nxt_rx_sh = {rx_sh_ff[14:0], din_s};
				if (bit_cnt_ff == adc_port_pkg::BIT_CNT_LAST) begin
					push = 1'b1;
					nxt_done = 1'b1;
					nxt_bit_cnt = '0;
				end else begin
					nxt_bit_cnt = bit_cnt_ff + 1'b1;
				end
			end
		end else begin
			nxt_bit_cnt = '0;
			nxt_done = 1'b0;
			nxt_mode1_frame = 1'b0;
		end
	end

	// shifter registers
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			frame_ff <= 1'b0;
			sclk_ff <= 1'b1; // idle level of the serial clock
			mclk_ff <= 1'b0;
			mode1_frame_ff <= 1'b0;
			done_ff <= 1'b0;
			bit_cnt_ff <= '0;
			rx_sh_ff <= '0;
			tx_sh_ff <= '0;
		end else if (ce) begin
			frame_ff <= nxt_frame;
			sclk_ff <= nxt_sclk;
			mclk_ff <= nxt_mclk;
			mode1_frame_ff <= nxt_mode1_frame;
			done_ff <= nxt_done;
			bit_cnt_ff <= nxt_bit_cnt;
			rx_sh_ff <= nxt_rx_sh;
			tx_sh_ff <= nxt_tx_sh;
		end
	end

	// pin drive: mode one reads back over the data input pin
	assign dout = tx_sh_ff[15] && !mode1_frame_ff;
	assign din_o = tx_sh_ff[15];
	assign din_oe = frame_ff && mode1_frame_ff;

	// ==========================================================
	// word buffer between shifter and register writer
	two_entry_buffer #(.WIDTH($bits(adc_port_pkg::rx_word_type)), .DEPTH(2)) u_word_buffer (
		.clock(clock),
		.nrst(nrst),
		.ce(ce),
		.in_valid(push),
		.in_ready(buf_in_ready),
		.in_data(in_word),
		.out_valid(buf_valid),
		.out_ready(buf_ready),
		.out_data(head_word)
	);
	assign word_ready = buf_in_ready;

	// ==========================================================
	// register set and converter sequencing
	logic [13:0] test_ff, nxt_test, result_ff, nxt_result;
	logic [13:0] cal_ff [CAL_REGS], nxt_cal [CAL_REGS];
	logic [3:0] cal_ptr_ff, nxt_cal_ptr;
	logic overrun_ff, nxt_overrun;
	logic [MW-1:0] mclk_cnt_ff, nxt_mclk_cnt;
	adc_port_pkg::op_state_type op_ff, nxt_op;
	logic [1:0] rd_sel;
	logic [15:0] status_word;
	// control writes wait while the converter is busy
	assign buf_ready = !(head_word.addr == adc_port_pkg::WADDR_CTRL && op_ff != adc_port_pkg::OP_IDLE);
	assign pop = buf_valid && buf_ready;
	assign rd_sel = ctrl_ff[adc_port_pkg::CTRL_RDSEL_HI:adc_port_pkg::CTRL_RDSEL_LO];

	// status view of block state
	always_comb begin
		status_word = '0;
		status_word[adc_port_pkg::STAT_BUSY_BIT] = (op_ff != adc_port_pkg::OP_IDLE);
		status_word[adc_port_pkg::STAT_CAL_BIT] = (op_ff == adc_port_pkg::OP_CALIBRATE);
		status_word[adc_port_pkg::STAT_OVR_BIT] = overrun_ff;
		status_word[adc_port_pkg::STAT_MODE1_BIT] = ctrl_ff[adc_port_pkg::CTRL_MODE1_BIT];
		status_word[adc_port_pkg::STAT_PTR_HI:adc_port_pkg::STAT_PTR_LO] = cal_ptr_ff;
	end

	// read source mux; control is never a source
	always_comb begin
		case (rd_sel)
			adc_port_pkg::RSEL_RESULT: rd_word = {2'h0, result_ff};
			adc_port_pkg::RSEL_TEST: rd_word = {2'h0, test_ff};
			adc_port_pkg::RSEL_CAL: rd_word = {2'h0, cal_ff[cal_ptr_ff]};
			default: rd_word = status_word;
		endcase
	end

	// register writes, read side effects and sequencing
	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_test = test_ff;
		nxt_result = result_ff;
		nxt_cal = cal_ff;
		nxt_cal_ptr = cal_ptr_ff;
		nxt_overrun = overrun_ff;
		nxt_mclk_cnt = mclk_cnt_ff;
		nxt_op = op_ff;
		if (frame_start) begin
			nxt_ctrl[adc_port_pkg::CTRL_MODE1_BIT] = 1'b0;
			if (rd_sel == adc_port_pkg::RSEL_CAL) begin
				nxt_cal_ptr = (cal_ptr_ff == 4'(CAL_REGS - 1)) ? '0 : cal_ptr_ff + 1'b1;
			end
			if (rd_sel == adc_port_pkg::RSEL_STATUS) begin
				nxt_overrun = 1'b0;
			end
		end
		if (push && !buf_in_ready) begin
			nxt_overrun = 1'b1; // set wins over the read clear
		end
		if (pop) begin
			case (head_word.addr)
				adc_port_pkg::WADDR_TEST: nxt_test = head_word.data;
				adc_port_pkg::WADDR_CAL: begin
					nxt_cal[cal_ptr_ff] = head_word.data;
					nxt_cal_ptr = (cal_ptr_ff == 4'(CAL_REGS - 1)) ? '0 : cal_ptr_ff + 1'b1;
				end
				adc_port_pkg::WADDR_CTRL: begin
					nxt_ctrl = head_word.data;
					nxt_cal_ptr = '0;
				end
				default: nxt_test = test_ff;
			endcase
		end
		case (op_ff)
			adc_port_pkg::OP_IDLE: begin
				nxt_mclk_cnt = '0;
				if (ctrl_ff[adc_port_pkg::CTRL_STCAL_BIT]) begin
					nxt_op = adc_port_pkg::OP_CALIBRATE;
				end else if (ctrl_ff[adc_port_pkg::CTRL_CONVST_BIT]) begin
					nxt_op = adc_port_pkg::OP_CONVERT;
				end
			end
			adc_port_pkg::OP_CONVERT: begin
				if (mclk_rise) begin
					if (mclk_cnt_ff == MW'(CONV_MCLKS - 1)) begin
						nxt_op = adc_port_pkg::OP_IDLE;
						nxt_result = sample_data;
						nxt_ctrl[adc_port_pkg::CTRL_CONVST_BIT] = 1'b0;
					end else begin
						nxt_mclk_cnt = mclk_cnt_ff + 1'b1;
					end
				end
			end
			adc_port_pkg::OP_CALIBRATE: begin
				if (mclk_rise) begin
					if (mclk_cnt_ff == MW'(CAL_MCLKS - 1)) begin
						nxt_op = adc_port_pkg::OP_IDLE;
						nxt_ctrl[adc_port_pkg::CTRL_STCAL_BIT] = 1'b0;
					end else begin
						nxt_mclk_cnt = mclk_cnt_ff + 1'b1;
					end
				end
			end
			default: nxt_op = adc_port_pkg::OP_IDLE;
		endcase
	end

	// register set, cleared to defaults at reset
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ctrl_ff <= adc_port_pkg::CTRL_RESET;
			test_ff <= adc_port_pkg::TEST_RESET;
			result_ff <= '0;
			for (int i = 0; i < CAL_REGS; i++) begin
				cal_ff[i] <= adc_port_pkg::CAL_RESET;
			end
			cal_ptr_ff <= '0;
			overrun_ff <= 1'b0;
			mclk_cnt_ff <= '0;
			op_ff <= adc_port_pkg::OP_IDLE;
		end else if (ce) begin
			ctrl_ff <= nxt_ctrl;
			test_ff <= nxt_test;
			result_ff <= nxt_result;
			cal_ff <= nxt_cal;
			cal_ptr_ff <= nxt_cal_ptr;
			overrun_ff <= nxt_overrun;
			mclk_cnt_ff <= nxt_mclk_cnt;
			op_ff <= nxt_op;
		end
	end
	assign busy = (op_ff != adc_port_pkg::OP_IDLE);
	assign ctrl_out = ctrl_ff;

	// ==========================================================
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	sequence s_frame_begin;
		ce && frame_start;
	endsequence
	sequence s_last_bit;
		ce && frame && !frame_start && sclk_fall && !done_ff && !mode1_frame_ff &&
			bit_cnt_ff == adc_port_pkg::BIT_CNT_LAST;
	endsequence
	a_idle_no_count: assert property (ce && !frame |=> bit_cnt_ff == '0)
		else $error("bit count kept outside a frame");
	a_word_push_only_last: assert property (push |-> frame && bit_cnt_ff == adc_port_pkg::BIT_CNT_LAST)
		else $error("word pushed before sixteen bits");
	a_last_bit_pushes: assert property (s_last_bit |-> push)
		else $error("complete word not pushed");
	a_no_push_outside: assert property (!frame |-> !push)
		else $error("word pushed outside a frame");
	a_din_drive_mode: assert property (din_oe |-> frame_ff && mode1_frame_ff && !dout)
		else $error("data input driven outside mode one read");
	a_load_read_word: assert property (s_frame_begin |=> tx_sh_ff == $past(rd_word))
		else $error("read word not loaded at frame start");
	a_shift_out_msb: assert property (ce && frame && !frame_start && sclk_rise |=>
		tx_sh_ff[15] == $past(tx_sh_ff[14]))
		else $error("output did not advance one bit");
	a_ctrl_rdsel_write: assert property (ce && pop && head_word.addr == adc_port_pkg::WADDR_CTRL |=>
		rd_sel == $past(head_word.data[adc_port_pkg::CTRL_RDSEL_HI:adc_port_pkg::CTRL_RDSEL_LO]))
		else $error("read select not taken from control write");
	a_none_addr_ignored: assert property (ce && pop && head_word.addr == adc_port_pkg::WADDR_NONE |=>
		$stable(test_ff) && $stable(cal_ptr_ff) && rd_sel == $past(rd_sel))
		else $error("null address write changed a register");
	a_conv_end: assert property (ce && op_ff == adc_port_pkg::OP_CONVERT && mclk_rise &&
		mclk_cnt_ff == MW'(CONV_MCLKS - 1) |=> !busy && !ctrl_ff[adc_port_pkg::CTRL_CONVST_BIT])
		else $error("conversion did not end on its count");
	a_test_readback: assert property (s_frame_begin ##0 (rd_sel == adc_port_pkg::RSEL_TEST) |=>
		tx_sh_ff == {2'h0, test_ff})
		else $error("test register read wrong");

endmodule

`default_nettype wire

// ==== dv/serial_host.sv ====
// host side model of the converter serial register port: frame, serial clock, data
// assumes the device samples every pin on its own clock; serial clock idles high
`timescale 1ns/1ps
`default_nettype none

module serial_host #(
	parameter int HALF = 10
) (
	// system clock
	input wire logic clock,
	// serial link pins
	output logic sclk,
	output logic sync_n,
	output logic din_drv,
	input wire logic dout,
	input wire logic din_line
);
	// ==========================================================
	// data line drive
	logic drive = 1'b0;
	logic tx_bit = 1'b0;
	logic pat = 1'b0;

	// pins idle with frame off and serial clock standing high
	initial begin
		sclk = 1'b1;
		sync_n = 1'b1;
	end

	// changing pattern while the line is released, so no stale bit survives
	always @(posedge clock) begin
		pat <= ~pat;
	end
	assign din_drv = drive ? tx_bit : pat;

	// ==========================================================
	// one framed transfer of nbits, most significant first
	task automatic frame(input logic [15:0] tx, input int nbits, input logic listen, output logic [15:0] rx);
		int i;
		logic [15:0] acc;
		acc = 16'h0000;
		@(posedge clock);
		sync_n <= 1'b0;
		drive <= ~listen;
		tx_bit <= tx[15];
		repeat (HALF) @(posedge clock);
		for (i = 0; i < nbits; i++) begin
			tx_bit <= tx[15 - i];
			repeat (HALF) @(posedge clock);
			sclk <= 1'b0;
			acc = {acc[14:0], listen ? din_line : dout};
			repeat (HALF) @(posedge clock);
			sclk <= 1'b1;
		end
		repeat (HALF) @(posedge clock);
		sync_n <= 1'b1;
		drive <= 1'b0;
		repeat (2 * HALF) @(posedge clock);
		rx = acc;
	endtask

	// stray serial clock edges with no frame open
	task automatic idle_clocks(input int n);
		repeat (n) begin
			repeat (HALF) @(posedge clock);
			sclk <= ~sclk;
		end
	endtask
endmodule
`default_nettype wire

// ==== dv/adc_serial_register_port_bench.sv ====
// self-checking bench for the converter serial register port
// assumes serial_host drives the link; master clock and samples made here
`timescale 1ns/1ps
`default_nettype none

module adc_serial_register_port_bench;
	// ==========================================================
	// clock, reset and pins
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic ce = 1'b1;
	logic master_clock_in = 1'b0;
	logic [13:0] sample_data = 14'h0000;
	logic sclk, sync_n, din_drv, din_line, din_o, din_oe, dout, busy, word_ready;
	logic [13:0] ctrl_out;
	int bad_count = 0;
	int cmp_count = 0;
	int mclk_half = 8;
	logic [15:0] rx;
	logic [13:0] d, s, t;
	logic [13:0] cal_vals [10];

	// system clock, 4 ns period
	initial begin
		forever #2 clock = ~clock;
	end

	// master clock, slowed when a long calibration is wanted
	always begin
		repeat (mclk_half) @(posedge clock);
		master_clock_in <= ~master_clock_in;
	end

	// resolved data pin: device wins while it drives
	assign din_line = din_oe ? din_o : din_drv;

	adc_serial_register_port #(.CAL_REGS(10), .CONV_MCLKS(2), .CAL_MCLKS(4)) dut (
		.clock(clock), .nrst(nrst), .ce(ce),
		.sclk(sclk), .sync_n(sync_n), .din_i(din_line), .din_o(din_o), .din_oe(din_oe), .dout(dout),
		.master_clock_in(master_clock_in), .sample_data(sample_data), .busy(busy),
		.word_ready(word_ready), .ctrl_out(ctrl_out)
	);

	serial_host #(.HALF(10)) host (
		.clock(clock), .sclk(sclk), .sync_n(sync_n), .din_drv(din_drv), .dout(dout), .din_line(din_line)
	);

	// ==========================================================
	// expectation and bus helpers
	function automatic logic [15:0] rd_word(input logic [13:0] v);
		return {2'b00, v};
	endfunction

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [1:0] a, input logic [13:0] v);
		logic [15:0] r;
		host.frame({a, v}, 16, 1'b0, r);
	endtask

	task automatic rd(input logic listen, output logic [15:0] r);
		host.frame(16'h0000, 16, listen, r);
	endtask

	task automatic wait_busy(input logic lvl);
		int n;
		n = 0;
		while (busy !== lvl && n < 5000) begin
			@(posedge clock);
			n++;
		end
		check({15'h0000, busy}, {15'h0000, lvl});
	endtask

	task automatic report_and_stop();
		if (bad_count == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// watchdog well beyond the expected run
	initial begin
		repeat (60000) @(posedge clock);
		bad_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		report_and_stop();
	end

	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(84));
		repeat (3) @(posedge clock);
		nrst <= 1'b1;
		repeat (5) @(posedge clock);
		check({din_oe, dout, busy, word_ready, 12'h000}, 16'h1000);
		check({2'b00, ctrl_out}, 16'h0000);
		// software conversion, result read from the default source
		s = 14'($urandom);
		sample_data <= s;
		wr(adc_port_pkg::WADDR_CTRL, 14'h0010);
		wait_busy(1'b0);
		sample_data <= 14'($urandom);
		rd(1'b0, rx);
		check(rx, rd_word(s));
		check({2'b00, ctrl_out}, 16'h0000);
		// empty address writes nothing
		d = 14'($urandom);
		wr(adc_port_pkg::WADDR_NONE, d);
		check({2'b00, ctrl_out}, 16'h0000);
		// clock enable low freezes the port: a whole frame goes unseen
		ce <= 1'b0;
		wr(adc_port_pkg::WADDR_CTRL, 14'h0040);
		ce <= 1'b1;
		repeat (4) @(posedge clock);
		check({2'b00, ctrl_out}, 16'h0000);
		// random control words, each followed by a broken frame and stray clocks
		repeat (4) begin
			d = 14'($urandom) & 14'h3FCE;
			wr(adc_port_pkg::WADDR_CTRL, d);
			check({2'b00, ctrl_out}, {2'b00, d});
			host.frame({2'b11, ~d}, 1 + $urandom_range(14), 1'b0, rx);
			host.idle_clocks(8);
			check({2'b00, ctrl_out}, {2'b00, d});
		end
		// test register round trip
		t = 14'($urandom);
		wr(adc_port_pkg::WADDR_TEST, t); // factory register, touched only in this round trip
		wr(adc_port_pkg::WADDR_CTRL, 14'h0040);
		rd(1'b0, rx);
		check(rx, rd_word(t));
		// all ten calibration registers, filled with another read source so frame starts keep the pointer
		wr(adc_port_pkg::WADDR_CTRL, 14'h0000);
		for (int i = 0; i < 10; i++) begin
			cal_vals[i] = 14'($urandom);
			wr(adc_port_pkg::WADDR_CAL, cal_vals[i]);
		end
		// then read them back from the first, wrapping once
		wr(adc_port_pkg::WADDR_CTRL, 14'h0080);
		for (int i = 0; i < 11; i++) begin
			rd(1'b0, rx);
			check(rx, rd_word(cal_vals[i % 10]));
		end
		// quiet status
		wr(adc_port_pkg::WADDR_CTRL, 14'h00C0);
		rd(1'b0, rx);
		check(rx, 16'h0000);
		// read on the data input pin, then back on the output pin
		wr(adc_port_pkg::WADDR_CTRL, 14'h0020);
		rd(1'b1, rx);
		check(rx, rd_word(s));
		check({2'b00, ctrl_out}, 16'h0000);
		rd(1'b0, rx);
		check(rx, rd_word(s));
		// long calibration stalls control writes until the buffer refuses
		mclk_half = 250;
		wr(adc_port_pkg::WADDR_CTRL, 14'h0001);
		check({15'h0000, busy}, 16'h0001);
		wr(adc_port_pkg::WADDR_CTRL, 14'h0040);
		wr(adc_port_pkg::WADDR_CTRL, 14'h00C0);
		check({word_ready, 1'b0, ctrl_out}, {2'b00, 14'h0001});
		wr(adc_port_pkg::WADDR_CTRL, 14'h0080);
		wait_busy(1'b0);
		mclk_half = 8;
		repeat (8) @(posedge clock);
		check({word_ready, 1'b0, ctrl_out}, {2'b10, 14'h00C0});
		rd(1'b0, rx);
		check(rx, 16'h0004);
		rd(1'b0, rx);
		check(rx, 16'h0000);
		report_and_stop();
	end
endmodule
`default_nettype wire
